//--- design/mtcs_pkg.sv
`default_nettype none
package mtcs_pkg;
    // register map on the wishbone slave (byte addresses, one word each)
    localparam logic [3:0]  TRAP_CTRL_STAT_OFS = 4'h0;
    localparam logic [3:0]  IRQ_STATUS_OFS     = 4'h4;
    localparam logic [3:0]  IRQ_MASK_OFS       = 4'h8;
    localparam logic [3:0]  TRAP_CAUSE_OFS     = 4'hC;
    localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

    // field positions of the trap control/status register
    localparam int NESTING_DISABLE_BIT   = 15;
    localparam int ACC_A_OVF_FLAG_BIT    = 14;
    localparam int ACC_B_OVF_FLAG_BIT    = 13;
    localparam int ACC_A_CAT_FLAG_BIT    = 12;
    localparam int ACC_B_CAT_FLAG_BIT    = 11;
    localparam int ACC_A_OVF_TRAP_EN_BIT = 10;
    localparam int ACC_B_OVF_TRAP_EN_BIT = 9;
    localparam int CAT_TRAP_EN_BIT       = 8;
    localparam int SHIFT_ERR_FLAG_BIT    = 7;

    // bits 15..1 implemented, hardware-set flags in bits 14..11 and 7; bit 0 unimplemented
    localparam logic [15:0] TCS_RESET     = 16'h0000;
    localparam logic [15:0] TCS_IMPL_MASK = 16'hFFFE;
    localparam logic [15:0] TCS_FLAG_MASK = 16'h7880;

    // interrupt status/mask layout: one bit per trap event
    localparam int IRQ_ACC_A_OVF = 0;
    localparam int IRQ_ACC_B_OVF = 1;
    localparam int IRQ_ACC_A_CAT = 2;
    localparam int IRQ_ACC_B_CAT = 3;
    localparam int IRQ_SHIFT_ERR = 4;
    localparam int IRQ_WIDTH     = 5;
    localparam logic [4:0] IRQ_RESET = 5'h00;
endpackage : mtcs_pkg
`default_nettype wire

//--- design/mtcs_sticky.sv
`default_nettype none
// one sticky flag: hardware set wins over software clear
module mtcs_sticky (
    input  wire logic CLK,        // core clock
    input  wire logic RST_N,      // sync reset, active low
    input  wire logic hw_set,     // hardware event
    input  wire logic sw_wr,      // software write of a value
    input  wire logic sw_val,     // value written
    output var  logic flag        // flag
);
    typedef struct packed {
        logic q;
    } mtcs_sticky_state_t;

    mtcs_sticky_state_t st_reg;
    mtcs_sticky_state_t st_next;

    // set beats a write so an event in the clearing cycle is kept
    always_comb begin
        st_next = st_reg;
        if (sw_wr) begin
            st_next.q = sw_val;
        end
        if (hw_set) begin
            st_next.q = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.q;
endmodule : mtcs_sticky
`default_nettype wire

//--- design/mtcs_top.sv
// Chosen here: the Wishbone slave port and the address map.
`default_nettype none
module mtcs_top (
    input  wire logic        CLK,            // 20 MHz core clock
    input  wire logic        RST_N,          // sync reset, active low
    input  wire logic        WB_CYC_I,       // wishbone cycle
    input  wire logic        WB_STB_I,       // wishbone strobe
    input  wire logic        WB_WE_I,        // wishbone write
    input  wire logic [3:0]  WB_ADR_I,       // wishbone byte address
    input  wire logic [3:0]  WB_SEL_I,       // wishbone byte lanes
    input  wire logic [31:0] WB_DAT_I,       // wishbone write data
    output var  logic [31:0] WB_DAT_O,       // wishbone read data
    output var  logic        WB_ACK_O,       // wishbone acknowledge
    input  wire logic        ACC_A_OVF,      // accumulator A overflow event
    input  wire logic        ACC_B_OVF,      // accumulator B overflow event
    input  wire logic        ACC_A_CAT,      // accumulator A catastrophic event
    input  wire logic        ACC_B_CAT,      // accumulator B catastrophic event
    input  wire logic        SHIFT_ERR,      // invalid accumulator shift event
    input  wire logic        IN_HANDLER,     // a handler is executing
    input  wire logic        IRQ_PENDING,    // an interrupt is pending
    output var  logic        TRAP_REQ,       // math trap request, level
    output var  logic        PREEMPT_OK,     // pending interrupt may preempt
    output var  logic [15:0] TRAP_CTRL_STAT, // register contents
    output var  logic        IRQ             // unmasked status interrupt
);
    typedef struct packed {
        logic [15:0] tcs;
        logic [4:0]  irq_status;
        logic [4:0]  irq_mask;
        logic [4:0]  cause;
        logic [31:0] dat;
        logic        ack;
        logic        trap_req;
        logic        preempt_ok;
        logic        irq;
    } mtcs_state_t;

    mtcs_state_t st_reg;
    mtcs_state_t st_next;

    // byte-lane merge of a 16-bit field
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : lane_merge

    // register image with the flag bits taken from the sticky cells
    function automatic logic [15:0] with_flags(input logic [15:0] img,
                                               input logic [4:0]  f);
        logic [15:0] r;
        r = img;
        r[mtcs_pkg::ACC_A_OVF_FLAG_BIT] = f[mtcs_pkg::IRQ_ACC_A_OVF];
        r[mtcs_pkg::ACC_B_OVF_FLAG_BIT] = f[mtcs_pkg::IRQ_ACC_B_OVF];
        r[mtcs_pkg::ACC_A_CAT_FLAG_BIT] = f[mtcs_pkg::IRQ_ACC_A_CAT];
        r[mtcs_pkg::ACC_B_CAT_FLAG_BIT] = f[mtcs_pkg::IRQ_ACC_B_CAT];
        r[mtcs_pkg::SHIFT_ERR_FLAG_BIT] = f[mtcs_pkg::IRQ_SHIFT_ERR];
        return r;
    endfunction : with_flags

    logic        req;
    logic        wr_tcs;
    logic [15:0] wr_val;
    logic [4:0]  ev;
    logic [4:0]  ev_flag;
    logic [4:0]  flag_q;
    logic [4:0]  flag_wdata;
    logic        a_ovf_trap;
    logic        b_ovf_trap;
    logic        cat_trap;

    // a new request only when ack is low, so ack is never high two cycles running
    assign req    = WB_CYC_I && WB_STB_I && !st_reg.ack;
    assign wr_tcs = req && WB_WE_I && (WB_ADR_I == mtcs_pkg::TRAP_CTRL_STAT_OFS);
    // unwritten lanes keep the live flags: the image lags the sticky cells a cycle
    assign wr_val = lane_merge(with_flags(st_reg.tcs, flag_q), WB_DAT_I, WB_SEL_I)
                    & mtcs_pkg::TCS_IMPL_MASK;

    // enables gate the overflow causes before they become traps
    assign a_ovf_trap = ACC_A_OVF && st_reg.tcs[mtcs_pkg::ACC_A_OVF_TRAP_EN_BIT];
    assign b_ovf_trap = ACC_B_OVF && st_reg.tcs[mtcs_pkg::ACC_B_OVF_TRAP_EN_BIT];
    assign cat_trap   = st_reg.tcs[mtcs_pkg::CAT_TRAP_EN_BIT];

    // a flag is set only by the cause of a trap that is taken
    assign ev[mtcs_pkg::IRQ_ACC_A_OVF] = a_ovf_trap;
    assign ev[mtcs_pkg::IRQ_ACC_B_OVF] = b_ovf_trap;
    assign ev[mtcs_pkg::IRQ_ACC_A_CAT] = ACC_A_CAT && cat_trap;
    assign ev[mtcs_pkg::IRQ_ACC_B_CAT] = ACC_B_CAT && cat_trap;
    assign ev[mtcs_pkg::IRQ_SHIFT_ERR] = SHIFT_ERR;
    assign ev_flag = ev;

    assign flag_wdata = {wr_val[mtcs_pkg::SHIFT_ERR_FLAG_BIT],
                         wr_val[mtcs_pkg::ACC_B_CAT_FLAG_BIT],
                         wr_val[mtcs_pkg::ACC_A_CAT_FLAG_BIT],
                         wr_val[mtcs_pkg::ACC_B_OVF_FLAG_BIT],
                         wr_val[mtcs_pkg::ACC_A_OVF_FLAG_BIT]};

    // one sticky cell per flag; a new event overrides a software write
    genvar gi;
    generate
        for (gi = 0; gi < mtcs_pkg::IRQ_WIDTH; gi++) begin : g_flag
            mtcs_sticky u_flag (
                .CLK     (CLK),
                .RST_N   (RST_N),
                .hw_set  (ev_flag[gi]),
                .sw_wr   (wr_tcs),
                .sw_val  (flag_wdata[gi]),
                .flag    (flag_q[gi])
            );
        end
    endgenerate

    // register update, bus answer and trap outputs
    always_comb begin
        st_next = st_reg;
        st_next.ack = req;
        if (wr_tcs) begin
            st_next.tcs = wr_val & ~mtcs_pkg::TCS_FLAG_MASK;
        end
        st_next.tcs = with_flags(st_next.tcs, flag_q);
        st_next.tcs[0] = 1'b0;
        // interrupt status: set wins over write-one-to-clear
        if (req && WB_WE_I && WB_SEL_I[0]
            && WB_ADR_I == mtcs_pkg::IRQ_STATUS_OFS) begin
            st_next.irq_status = st_reg.irq_status & ~WB_DAT_I[4:0];
        end
        st_next.irq_status = st_next.irq_status | ev;
        if (req && WB_WE_I && WB_SEL_I[0]
            && WB_ADR_I == mtcs_pkg::IRQ_MASK_OFS) begin
            st_next.irq_mask = WB_DAT_I[4:0];
        end
        // last trap causes seen, kept for software
        if (|ev) begin
            st_next.cause = ev;
        end
        st_next.dat = mtcs_pkg::UNMAPPED_READ;
        if (req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                mtcs_pkg::TRAP_CTRL_STAT_OFS: st_next.dat = {16'h0000, st_reg.tcs};
                mtcs_pkg::IRQ_STATUS_OFS:     st_next.dat = {27'h0000000, st_reg.irq_status};
                mtcs_pkg::IRQ_MASK_OFS:       st_next.dat = {27'h0000000, st_reg.irq_mask};
                mtcs_pkg::TRAP_CAUSE_OFS:     st_next.dat = {27'h0000000, st_reg.cause};
                default:                      st_next.dat = mtcs_pkg::UNMAPPED_READ;
            endcase
        end
        st_next.trap_req = |ev;
        // nesting disable refuses preemption while a handler runs
        st_next.preempt_ok = IRQ_PENDING
            && !(IN_HANDLER && st_reg.tcs[mtcs_pkg::NESTING_DISABLE_BIT]);
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg <= '{tcs: mtcs_pkg::TCS_RESET, irq_status: mtcs_pkg::IRQ_RESET,
                        irq_mask: mtcs_pkg::IRQ_RESET, cause: mtcs_pkg::IRQ_RESET,
                        dat: mtcs_pkg::UNMAPPED_READ, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign WB_DAT_O       = st_reg.dat;
    assign WB_ACK_O       = st_reg.ack;
    assign TRAP_REQ       = st_reg.trap_req;
    assign PREEMPT_OK     = st_reg.preempt_ok;
    assign TRAP_CTRL_STAT = st_reg.tcs;
    assign IRQ            = st_reg.irq;
endmodule : mtcs_top
`default_nettype wire

//--- testbench/mtcs_core_model.sv
`default_nettype none
// far-side datapath: event pulses and handler context
module mtcs_core_model (
    input  wire logic       CLK,  // core clock
    output var  logic [4:0] ev,   // a ovf, b ovf, a cat, b cat, shift
    output var  logic       in_h, // handler running
    output var  logic       pend  // interrupt pending
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ev = 5'h00;
        in_h = 1'b0;
        pend = 1'b0;
    end
    // single-cycle pulse, a held level would count as an event in every cycle
    task automatic fire(input int i);
        @(posedge CLK);
        ev <= 5'h01 << i;
        @(posedge CLK);
        ev <= 5'h00;
    endtask : fire
    task automatic ctx(input logic h, input logic p);
        @(posedge CLK);
        in_h <= h;
        pend <= p;
    endtask : ctx
endmodule : mtcs_core_model
`default_nettype wire

//--- testbench/mtcs_top_properties.sv
`default_nettype none
module mtcs_checker (
    input wire logic        CLK,            // clock
    input wire logic        RST_N,          // reset
    input wire logic        WB_CYC_I,       // cycle
    input wire logic        WB_STB_I,       // strobe
    input wire logic        WB_ACK_O,       // ack
    input wire logic        ACC_A_OVF,      // events
    input wire logic        ACC_B_OVF,
    input wire logic        ACC_A_CAT,
    input wire logic        ACC_B_CAT,
    input wire logic        SHIFT_ERR,
    input wire logic        IN_HANDLER,     // handler running
    input wire logic        IRQ_PENDING,    // pending
    input wire logic        TRAP_REQ,       // trap request
    input wire logic        PREEMPT_OK,     // preempt allowed
    input wire logic [15:0] TRAP_CTRL_STAT  // register image
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    // event through sticky cell, then register: two edges
    property p_flag(ev, en, b);
        ev && en |=> ##1 TRAP_CTRL_STAT[b];
    endproperty
    a_ack_after_req: assert property (s_req |=> WB_ACK_O) else $error("no ack");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
    a_bit0_zero: assert property (!TRAP_CTRL_STAT[0]) else $error("bit 0 set");
    a_nest_block: assert property ($past(RST_N) |-> PREEMPT_OK ==
        $past(IRQ_PENDING && !(IN_HANDLER && TRAP_CTRL_STAT[15]))) else $error("preempt");
    a_trap_gate: assert property ($past(RST_N) |-> TRAP_REQ == $past(
        (ACC_A_OVF && TRAP_CTRL_STAT[10]) || (ACC_B_OVF && TRAP_CTRL_STAT[9]) ||
        ((ACC_A_CAT || ACC_B_CAT) && TRAP_CTRL_STAT[8]) || SHIFT_ERR)) else $error("trap");
    a_ovf_a_flag: assert property (p_flag(ACC_A_OVF, TRAP_CTRL_STAT[10], 14))
        else $error("a ovf");
    a_ovf_b_flag: assert property (p_flag(ACC_B_OVF, TRAP_CTRL_STAT[9], 13))
        else $error("b ovf");
    a_cat_a_flag: assert property (p_flag(ACC_A_CAT, TRAP_CTRL_STAT[8], 12))
        else $error("a cat");
    a_cat_b_flag: assert property (p_flag(ACC_B_CAT, TRAP_CTRL_STAT[8], 11))
        else $error("b cat");
    a_shift_flag: assert property (p_flag(SHIFT_ERR, 1'b1, 7)) else $error("shift");
endmodule : mtcs_checker
bind mtcs_top mtcs_checker u_chk (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .ACC_A_OVF(ACC_A_OVF), .ACC_B_OVF(ACC_B_OVF),
    .ACC_A_CAT(ACC_A_CAT), .ACC_B_CAT(ACC_B_CAT), .SHIFT_ERR(SHIFT_ERR),
    .IN_HANDLER(IN_HANDLER), .IRQ_PENDING(IRQ_PENDING), .TRAP_REQ(TRAP_REQ),
    .PREEMPT_OK(PREEMPT_OK), .TRAP_CTRL_STAT(TRAP_CTRL_STAT));
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h3;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r, q;
    logic [15:0] tcs;
    logic [4:0]  ev;
    logic        ack, in_h, pend, trap_req, pre_ok, irq;
    int          mismatches = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [15:0] en_tab [5] = '{16'h0400, 16'h0200, 16'h0100, 16'h0100, 16'h0000};
    logic [15:0] flg_tab [5] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0080};
    mtcs_top dut (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .ACC_A_OVF(ev[0]), .ACC_B_OVF(ev[1]), .ACC_A_CAT(ev[2]), .ACC_B_CAT(ev[3]),
        .SHIFT_ERR(ev[4]), .IN_HANDLER(in_h), .IRQ_PENDING(pend), .TRAP_REQ(trap_req),
        .PREEMPT_OK(pre_ok), .TRAP_CTRL_STAT(tcs), .IRQ(irq));
    mtcs_core_model u_core (.CLK(clk), .ev(ev), .in_h(in_h), .pend(pend));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // a hung handshake ends here instead of running forever
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // classic cycle: hold until ack is sampled high, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'h3);
        @(posedge clk);
        {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, s};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_r;
        {cyc, stb, we} <= 3'b000;
    endtask : wb
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdc
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc(4'h0, 32'h0);
        wb(1'b1, 4'h0, 32'hFFFF);
        rdc(4'h0, 32'hFFFE);
        wb(1'b1, 4'h0, 32'h0);
        rdc(4'h0, 32'h0);
        // enables clear: no overflow or catastrophic event may leave a flag
        for (int i = 0; i < 4; i++) begin
            u_core.fire(i);
            @(posedge clk);
            chk(trap_req, 1'b0);
        end
        repeat (3) @(posedge clk);
        rdc(4'h0, 32'h0);
        $display("test gating done");
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 4'h0, {16'h0, en_tab[i]});
            u_core.fire(i);
            @(posedge clk);
            chk(trap_req, 1'b1);
            @(posedge clk);
            chk(tcs, {16'h0, en_tab[i] | flg_tab[i]});
            rdc(4'h0, {16'h0, en_tab[i] | flg_tab[i]});
            wb(1'b1, 4'h0, {16'h0, en_tab[i]});
            rdc(4'h0, {16'h0, en_tab[i]});
        end
        $display("test flags done");
        // clearing write and new event in one cycle: event wins
        wb(1'b1, 4'h0, 32'h0400);
        fork
            wb(1'b1, 4'h0, 32'h0400);
            u_core.fire(0);
        join
        repeat (2) @(posedge clk);
        rdc(4'h0, 32'h4400);
        rdc(4'hC, 32'h01);
        // single-lane writes leave the other byte and its live flags alone
        wb(1'b1, 4'h0, 32'h00FE, 4'h1);
        rdc(4'h0, 32'h44FE);
        wb(1'b1, 4'h0, 32'h0000, 4'h2);
        rdc(4'h0, 32'h00FE);
        rdc(4'h4, 32'h1F);
        chk(irq, 1'b0);
        wb(1'b1, 4'h8, 32'h1F);
        @(posedge clk);
        chk(irq, 1'b1);
        wb(1'b1, 4'h4, 32'h1F);
        @(posedge clk);
        chk(irq, 1'b0);
        rdc(4'h4, 32'h0);
        $display("test irq done");
        wb(1'b1, 4'h0, 32'h0);
        u_core.ctx(1'b1, 1'b1);
        repeat (2) @(posedge clk);
        chk(pre_ok, 1'b1);
        u_core.ctx(1'b0, 1'b0);
        wb(1'b1, 4'h0, 32'h8000);
        u_core.ctx(1'b1, 1'b1);
        repeat (2) @(posedge clk);
        chk(pre_ok, 1'b0);
        u_core.ctx(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        chk(pre_ok, 1'b1);
        $display("test nesting done");
        summarize();
    end
endmodule : tb
`default_nettype wire
